// [hw/adc_map.svh]
/*
 holds every address, frame figure, configuration reset value and timing figure
 of the converter result port as macros.
 assumes it is included by bare name from the design files.
*/
`ifndef ADC_MAP_SVH
`define ADC_MAP_SVH

// ----------------------------------------
// target addresses (7 bits)
// ----------------------------------------
`define ADC_ADDR_LO_HI 7'h14
`define ADC_ADDR_LO_FL 7'h15
`define ADC_ADDR_FL_HI 7'h17
`define ADC_ADDR_FL_FL 7'h24
`define ADC_ADDR_HI_HI 7'h26
`define ADC_ADDR_HI_FL 7'h27
`define ADC_ADDR_GLOBAL 7'h77

// ----------------------------------------
// frame layout
// ----------------------------------------
`define ADC_BIT_CNT 4'h8
`define ADC_BYTE_CNT 2'h3
`define ADC_WORD_MSB 23
`define ADC_CFG_READBACK 6

// ----------------------------------------
// configuration byte layout and reset
// ----------------------------------------
`define ADC_CFG_RESET 7'h00
`define ADC_REJ_BOTH 2'h0
`define ADC_REJ_50 2'h1
`define ADC_REJ_60 2'h2

// ----------------------------------------
// result clamping (18-bit offset code)
// ----------------------------------------
`define ADC_FS_POS 20'sh10000
`define ADC_FS_NEG_M1 -20'sh10001
`define ADC_CODE_MID 20'sh20000

// ----------------------------------------
// conversion times in microseconds
// ----------------------------------------
`define ADC_CLK_MHZ 200
`define ADC_T60_US 133000
`define ADC_T50_US 160000
`define ADC_TBOTH_US 147000
`define ADC_T60_2X_US 67000
`define ADC_T50_2X_US 80000
`define ADC_TBOTH_2X_US 73600
`define ADC_US2CYC(us) ((us) * `ADC_CLK_MHZ)

// ----------------------------------------
// filter side reset stretch in clk cycles
// ----------------------------------------
// the top bit of the counter is what crosses, so keep this at least 4'h8
`define ADC_RST_HOLD 4'hf

`endif

// [hw/adc_pkg.sv]
/*
 types shared by the converter result port.
 assumes adc_map.svh sits beside it on the include path.
*/
package adc_pkg;

    // engine states of the serial target
    typedef enum logic [2:0] {
        ADC_IDLE = 3'b000,
        ADC_ADDR = 3'b001,
        ADC_AACK = 3'b010,
        ADC_RD = 3'b011,
        ADC_RACK = 3'b100,
        ADC_WR = 3'b101,
        ADC_WACK = 3'b110
    } adc_state_t;

    // converter configuration register
    typedef struct packed {
        logic temp_input_select;
        logic [1:0] rejection;
        logic double_speed_select;
        logic gain_select_bit2;
        logic gain_select_bit1;
        logic gain_select_bit0;
    } adc_cfg_t;

    // sensed levels of the address select pads
    typedef struct packed {
        logic pin_b_high;
        logic pin_b_float;
        logic pin_a_high;
        logic pin_a_float;
        logic ext_clock_valid;
    } adc_pins_t;

endpackage

// [hw/adc_i2c_result_port.sv]
/*
 serial target and conversion sequencer of the converter: address
 match, ack or refusal, result word shift-out, configuration write,
 conversion timing, and result capture from the filter domain.
 assumes scl, sda and the pad sense levels are asynchronous, and that
 the filter sample is valid on conv_clk at every edge.
*/
`timescale 1ns/10ps
`include "adc_map.svh"

module adc_i2c_result_port
    import adc_pkg::*;
#(
    parameter int unsigned T60_CYC = `ADC_US2CYC(`ADC_T60_US),
    parameter int unsigned T50_CYC = `ADC_US2CYC(`ADC_T50_US),
    parameter int unsigned TBOTH_CYC = `ADC_US2CYC(`ADC_TBOTH_US),
    parameter int unsigned T60_2X_CYC = `ADC_US2CYC(`ADC_T60_2X_US),
    parameter int unsigned T50_2X_CYC = `ADC_US2CYC(`ADC_T50_2X_US),
    parameter int unsigned TBOTH_2X_CYC = `ADC_US2CYC(`ADC_TBOTH_2X_US)
)
(
    // system clock and reset
    input wire logic clk,
    input wire logic reset,
    // serial bus, open drain
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_drive_n,
    // address select pad sense
    input wire adc_pins_t pins,
    // filter domain
    input wire logic conv_clk,
    input wire logic signed [19:0] conv_sample,
    // settings towards the front end
    output logic conv_run,
    output adc_cfg_t conv_cfg
);

    // ----------------------------------------
    // elaboration check
    // ----------------------------------------
    // a zero count would wrap the timer
    if (T60_CYC < 1 || T50_CYC < 1 || TBOTH_CYC < 1 ||
        T60_2X_CYC < 1 || T50_2X_CYC < 1 || TBOTH_2X_CYC < 1)
    begin : g_bad_time
        $error("conversion counts must be at least one");
    end

    // ----------------------------------------
    // functions
    // ----------------------------------------
    // pin-selected address; bit 7 set when the strapping is legal
    function automatic logic [7:0] addr_of(input adc_pins_t p);
        logic a_hi;
        logic [6:0] a;
        logic ok;
        a_hi = p.pin_a_high | p.ext_clock_valid;
        a = 7'h00;
        ok = 1'b1;
        if (p.pin_b_float)
        begin
            a = a_hi ? `ADC_ADDR_FL_HI : `ADC_ADDR_FL_FL;
        end
        else if (p.pin_b_high)
        begin
            a = a_hi ? `ADC_ADDR_HI_HI : `ADC_ADDR_HI_FL;
        end
        else
        begin
            a = a_hi ? `ADC_ADDR_LO_HI : `ADC_ADDR_LO_FL;
        end
        // a pad driven low on the shared pin is no legal address
        if (!a_hi && !p.pin_a_float)
        begin
            ok = 1'b0;
        end
        return {ok, a};
    endfunction

    // settings the next conversion really runs with
    function automatic adc_cfg_t effective(input adc_cfg_t c);
        adc_cfg_t e;
        e = c;
        if (c.temp_input_select)
        begin
            e.double_speed_select = 1'b0;
            e.gain_select_bit2 = 1'b0;
            e.gain_select_bit1 = 1'b0;
            e.gain_select_bit0 = 1'b0;
        end
        return e;
    endfunction

    // conversion length in clk cycles, less one for the down count
    function automatic logic [31:0] dur_of(input adc_cfg_t e);
        int unsigned n;
        n = TBOTH_CYC;
        case (e.rejection)
            `ADC_REJ_50: n = e.double_speed_select ? T50_2X_CYC : T50_CYC;
            `ADC_REJ_60: n = e.double_speed_select ? T60_2X_CYC : T60_CYC;
            default: n = e.double_speed_select ? TBOTH_2X_CYC : TBOTH_CYC;
        endcase
        return 32'(n - 1);
    endfunction

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    logic scl_s1_q, scl_s2_q, scl_s3_q; // scl sync plus history
    logic sda_s1_q, sda_s2_q, sda_s3_q; // sda sync plus history
    adc_pins_t pins_s1_q, pins_s2_q; // pad sense sync
    logic ack_s1_q, ack_s2_q, ack_s3_q; // capture toggle from filter side
    logic ack_tgl_c_q; // capture toggle, filter side
    logic [17:0] word_c_q; // formatted result, filter side

    // two-flop chains, with a third history flop on scl, sda and ack; stage one feeds only stage two
    always_ff @(posedge clk)
    begin
        scl_s1_q <= scl;
        scl_s2_q <= scl_s1_q;
        scl_s3_q <= scl_s2_q;
        sda_s1_q <= sda_in;
        sda_s2_q <= sda_s1_q;
        sda_s3_q <= sda_s2_q;
        pins_s1_q <= pins;
        pins_s2_q <= pins_s1_q;
        ack_s1_q <= ack_tgl_c_q;
        ack_s2_q <= ack_s1_q;
        ack_s3_q <= ack_s2_q;
    end

    // bus events, all from the second and third stages
    logic scl_rise, scl_fall, bus_start, bus_stop, cap_done;
    assign scl_rise = scl_s2_q & ~scl_s3_q;
    assign scl_fall = ~scl_s2_q & scl_s3_q;
    // sda moving while scl stays high marks start or stop
    assign bus_start = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
    assign bus_stop = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;
    assign cap_done = ack_s2_q ^ ack_s3_q;

    // ----------------------------------------
    // serial engine and sequencer, clk domain
    // ----------------------------------------
    adc_state_t st_q, st_d; // engine state
    logic [3:0] bit_q, bit_d; // bits seen in this byte
    logic [7:0] sh_q, sh_d; // receive shifter
    logic [23:0] tx_q, tx_d; // transmit shifter
    logic [1:0] nbyte_q, nbyte_d; // bytes read out
    logic rw_q, rw_d; // direction of the accepted request
    logic io_q, io_d; // in the data input/output phase
    logic drv_n_q, drv_n_d; // sda pulled low when zero
    logic sda_out_q; // level driven when enabled
    adc_cfg_t cfg_q, cfg_d; // configuration register
    adc_cfg_t ccfg_q, ccfg_d; // settings of the running conversion
    logic ready_q, ready_d; // sleeping with a result held
    logic run_q, run_d; // conversion timer running
    logic boot_q, boot_d; // first conversion after reset
    logic [31:0] tmr_q, tmr_d; // conversion down counter
    logic req_tgl_q, req_tgl_d; // capture request to filter side
    logic [17:0] word_q, word_d; // conversion output word, upper part
    logic go; // start a new conversion this cycle
    logic [7:0] own; // own address with legal flag
    logic hit; // address byte selects this device

    always_comb
    begin
        st_d = st_q;
        bit_d = bit_q;
        sh_d = sh_q;
        tx_d = tx_q;
        nbyte_d = nbyte_q;
        rw_d = rw_q;
        io_d = io_q;
        drv_n_d = drv_n_q;
        cfg_d = cfg_q;
        ccfg_d = ccfg_q;
        ready_d = ready_q;
        run_d = run_q;
        boot_d = 1'b0;
        tmr_d = tmr_q;
        req_tgl_d = req_tgl_q;
        word_d = word_q;
        go = boot_q; // conversion begins right after reset
        own = addr_of(pins_s2_q);
        hit = (own[7] && sh_q[7:1] == own[6:0]) ||
              (sh_q[7:1] == `ADC_ADDR_GLOBAL && !sh_q[0]);

        if (bus_stop)
        begin
            // stop inside the io phase ends it; covers the abort
            // in the ack slot and a write with or without a byte
            go = io_q;
            io_d = 1'b0;
            drv_n_d = 1'b1;
            st_d = ADC_IDLE;
        end
        else if (bus_start)
        begin
            // repeated start keeps the io phase open
            st_d = ADC_ADDR;
            bit_d = 4'h0;
            drv_n_d = 1'b1;
        end
        else
        begin
            case (st_q)
                ADC_ADDR:
                begin
                    // seven address bits then the direction bit
                    if (scl_rise)
                    begin
                        sh_d = {sh_q[6:0], sda_s2_q};
                        bit_d = bit_q + 4'h1;
                    end
                    else if (scl_fall && bit_q == `ADC_BIT_CNT)
                    begin
                        if (hit && ready_q)
                        begin
                            // acknowledge and leave sleep
                            drv_n_d = 1'b0;
                            rw_d = sh_q[0];
                            io_d = 1'b1;
                            st_d = ADC_AACK;
                        end
                        else
                        begin
                            // busy or not ours: sda stays released
                            st_d = ADC_IDLE;
                        end
                    end
                end
                ADC_AACK:
                begin
                    if (scl_fall)
                    begin
                        bit_d = 4'h0;
                        nbyte_d = 2'h0;
                        if (rw_q)
                        begin
                            // result plus configuration readback
                            tx_d = {word_q, cfg_q[`ADC_CFG_READBACK-1:0]};
                            drv_n_d = word_q[17];
                            st_d = ADC_RD;
                        end
                        else
                        begin
                            drv_n_d = 1'b1;
                            st_d = ADC_WR;
                        end
                    end
                end
                ADC_RD:
                begin
                    if (scl_rise)
                    begin
                        bit_d = bit_q + 4'h1;
                    end
                    else if (scl_fall)
                    begin
                        if (bit_q == `ADC_BIT_CNT)
                        begin
                            // release for the master's ack slot
                            drv_n_d = 1'b1;
                            bit_d = 4'h0;
                            nbyte_d = nbyte_q + 2'h1;
                            st_d = ADC_RACK;
                        end
                        else
                        begin
                            // next bit, msb first, on the falling edge
                            drv_n_d = tx_q[22];
                            tx_d = {tx_q[22:0], 1'b0};
                        end
                    end
                end
                ADC_RACK:
                begin
                    if (scl_rise)
                    begin
                        if (nbyte_q == `ADC_BYTE_CNT)
                        begin
                            // all 24 bits gone: empty and reconvert
                            go = 1'b1;
                            io_d = 1'b0;
                            st_d = ADC_IDLE;
                        end
                        else if (sda_s2_q)
                        begin
                            // master declined more; wait for stop
                            st_d = ADC_IDLE;
                        end
                        else
                        begin
                            st_d = ADC_RD;
                        end
                    end
                end
                ADC_WR:
                begin
                    if (scl_rise)
                    begin
                        sh_d = {sh_q[6:0], sda_s2_q};
                        bit_d = bit_q + 4'h1;
                    end
                    else if (scl_fall && bit_q == `ADC_BIT_CNT)
                    begin
                        // used only from the next conversion start
                        cfg_d = adc_cfg_t'(sh_q[6:0]);
                        drv_n_d = 1'b0;
                        st_d = ADC_WACK;
                    end
                end
                ADC_WACK:
                begin
                    if (scl_fall)
                    begin
                        drv_n_d = 1'b1;
                        bit_d = 4'h0;
                        st_d = ADC_WR;
                    end
                end
                default:
                begin
                    st_d = ADC_IDLE;
                end
            endcase
        end

        // conversion timer; at the end ask the filter side to capture
        if (run_q)
        begin
            if (tmr_q == 32'h0)
            begin
                run_d = 1'b0;
                req_tgl_d = ~req_tgl_q;
            end
            else
            begin
                tmr_d = tmr_q - 32'h1;
            end
        end

        // captured word arrived: sleep with it held
        if (cap_done)
        begin
            word_d = word_c_q;
            ready_d = 1'b1;
        end

        // start: the output register counts as emptied
        if (go)
        begin
            ready_d = 1'b0;
            run_d = 1'b1;
            ccfg_d = effective(cfg_d);
            tmr_d = dur_of(effective(cfg_d));
        end
    end

    // registers only; synchronous reset
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            st_q <= ADC_IDLE;
            bit_q <= 4'h0;
            sh_q <= 8'h00;
            tx_q <= 24'h000000;
            nbyte_q <= 2'h0;
            rw_q <= 1'b0;
            io_q <= 1'b0;
            drv_n_q <= 1'b1;
            sda_out_q <= 1'b0;
            cfg_q <= adc_cfg_t'(`ADC_CFG_RESET);
            ccfg_q <= adc_cfg_t'(`ADC_CFG_RESET);
            ready_q <= 1'b0;
            run_q <= 1'b0;
            boot_q <= 1'b1;
            tmr_q <= 32'h0;
            req_tgl_q <= 1'b0;
            word_q <= 18'h00000;
        end
        else
        begin
            st_q <= st_d;
            bit_q <= bit_d;
            sh_q <= sh_d;
            tx_q <= tx_d;
            nbyte_q <= nbyte_d;
            rw_q <= rw_d;
            io_q <= io_d;
            drv_n_q <= drv_n_d;
            sda_out_q <= 1'b0;
            cfg_q <= cfg_d;
            ccfg_q <= ccfg_d;
            ready_q <= ready_d;
            run_q <= run_d;
            boot_q <= boot_d;
            tmr_q <= tmr_d;
            req_tgl_q <= req_tgl_d;
            word_q <= word_d;
        end
    end

    // ----------------------------------------
    // result capture, conv_clk domain
    // ----------------------------------------
    logic rst_c1_q, rst_c2_q; // reset brought into this domain
    logic req_c1_q, req_c2_q; // capture request sync
    logic alt_c_q, alt_c_d; // sign alternation for zero codes
    logic [17:0] word_c_d;
    logic ack_tgl_c_d;
    logic signed [19:0] clamped; // sample held inside +fs .. -fs-1
    logic [3:0] rst_hold_q, rst_hold_d; // reset stretched for the slower clock

    // a reset of two clk cycles can fall between two conv_clk edges,
    // so a counter holds the filter side reset a little longer
    always_comb
    begin
        rst_hold_d = rst_hold_q;
        if (rst_hold_q != 4'h0)
        begin
            rst_hold_d = rst_hold_q - 4'h1;
        end
    end

    // registers only; loaded while reset stands
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            rst_hold_q <= `ADC_RST_HOLD;
        end
        else
        begin
            rst_hold_q <= rst_hold_d;
        end
    end

    // top counter bit is a flop, so it crosses without glitches
    always_ff @(posedge conv_clk)
    begin
        rst_c1_q <= rst_hold_q[3];
        rst_c2_q <= rst_c1_q;
        req_c1_q <= req_tgl_q;
        req_c2_q <= req_c1_q;
    end

    // ccfg_q is still when sampled: it only moves at a start,
    // and a start never comes before this side answers
    always_comb
    begin
        word_c_d = word_c_q;
        ack_tgl_c_d = ack_tgl_c_q;
        alt_c_d = alt_c_q;
        clamped = conv_sample;
        if (conv_sample > `ADC_FS_POS)
        begin
            clamped = `ADC_FS_POS;
        end
        else if (conv_sample < `ADC_FS_NEG_M1)
        begin
            clamped = `ADC_FS_NEG_M1;
        end
        // level compare: a request that toggled during reset still gets served
        if (req_c2_q != ack_tgl_c_q)
        begin
            // offset by mid scale: sign, msb, then two's complement
            word_c_d = 18'(clamped + `ADC_CODE_MID);
            if (ccfg_q.double_speed_select && clamped == 20'sh0)
            begin
                // uncalibrated zero: sign flips between readings
                word_c_d[17] = ~alt_c_q;
                alt_c_d = ~alt_c_q;
            end
            ack_tgl_c_d = ~ack_tgl_c_q;
        end
    end

    always_ff @(posedge conv_clk)
    begin
        if (rst_c2_q)
        begin
            word_c_q <= 18'h00000;
            ack_tgl_c_q <= 1'b0;
            alt_c_q <= 1'b0;
        end
        else
        begin
            word_c_q <= word_c_d;
            ack_tgl_c_q <= ack_tgl_c_d;
            alt_c_q <= alt_c_d;
        end
    end

    // ----------------------------------------
    // outputs, all from flops
    // ----------------------------------------
    assign sda_out = sda_out_q;
    assign sda_drive_n = drv_n_q;
    assign conv_run = run_q;
    assign conv_cfg = ccfg_q;

endmodule

// [verif/adc_i2c_props.sv]
/* checker for the result port.
   assumes it is bound to the port's top and sees only its ports. */
`timescale 1ns/10ps
module adc_i2c_props
    import adc_pkg::*;
#(
    parameter int unsigned TBOTH_CYC = 200
)
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // serial bus
    input wire logic scl,
    input wire logic sda_out,
    input wire logic sda_drive_n,
    // converter side
    input wire logic conv_run,
    input wire adc_cfg_t conv_cfg
);
    // ------------
    // helpers
    // ------------
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    int unsigned run_cnt_q;
    int unsigned run_cnt_d;
    // length of the running conversion
    always_comb run_cnt_d = conv_run ? run_cnt_q + 32'h1 : 32'h0;
    always_ff @(posedge clk) run_cnt_q <= reset ? 32'h0 : run_cnt_d;
    sequence s_run_end;
        conv_run ##1 !conv_run;
    endsequence
    sequence s_running;
        conv_run [*3];
    endsequence
    // ------------
    // checks
    // ------------
    a_out_low: assert property (sda_out == 1'b0)
        else $error("pad level not low");
    a_rst_quiet: assert property (disable iff (1'b0)
        reset |=> sda_drive_n && !conv_run && conv_cfg == 7'h00)
        else $error("reset values wrong");
    a_boot_run: assert property ($fell(reset) |-> ##[0:4] conv_run)
        else $error("no conversion after reset");
    a_busy_quiet: assert property (conv_run |-> sda_drive_n)
        else $error("drives bus while converting");
    a_edge_scl_low: assert property ($changed(sda_drive_n) |-> !scl)
        else $error("data changed with clock high");
    a_cfg_hold: assert property (s_running |-> $stable(conv_cfg))
        else $error("settings moved mid conversion");
    a_temp_gain: assert property (conv_cfg.temp_input_select |-> conv_cfg[3:0] == 4'h0)
        else $error("temperature input not gain one");
    a_run_len: assert property (s_run_end |->
        run_cnt_q + 32'h4 >= TBOTH_CYC && run_cnt_q <= TBOTH_CYC + 32'h4)
        else $error("conversion length wrong");
endmodule
bind adc_i2c_result_port adc_i2c_props #(.TBOTH_CYC(TBOTH_CYC)) u_props
(
    .clk(clk),
    .reset(reset),
    .scl(scl),
    .sda_out(sda_out),
    .sda_drive_n(sda_drive_n),
    .conv_run(conv_run),
    .conv_cfg(conv_cfg)
);

// [verif/adc_i2c_master.sv]
/* behavioural bus master for the result port.
   assumes the bench resolves the pulled-up data wire. */
`timescale 1ns/10ps
module adc_i2c_master
(
    // clock
    input wire logic clk,
    // bus
    output logic scl,
    output logic sda_pull,
    input wire logic sda,
    // ack and byte seen, toggle per byte
    output logic rd_v,
    output logic [8:0] rd_d
);
    // idle bus: both lines released
    initial
    begin
        scl = 1'b1;
        sda_pull = 1'b0;
        rd_v = 1'b0;
        rd_d = 9'h000;
    end
    // third of a bit, four times the port's sync delay
    task automatic qtr;
        repeat (8) @(posedge clk);
        #1;
    endtask
    // one bit out, wire level back at the end of high
    task automatic bit_io(input logic b, output logic r);
        sda_pull = ~b;
        qtr;
        scl = 1'b1;
        qtr;
        r = sda;
        scl = 1'b0;
        qtr;
    endtask
    // start or repeated start
    task automatic start;
        sda_pull = 1'b0;
        qtr;
        scl = 1'b1;
        qtr;
        sda_pull = 1'b1;
        qtr;
        scl = 1'b0;
        qtr;
    endtask
    // stop, only ever after an ack slot
    task automatic stop;
        sda_pull = 1'b1;
        qtr;
        scl = 1'b1;
        qtr;
        sda_pull = 1'b0;
        qtr;
    endtask
    // eight bits msb first, then the ack slot
    task automatic xfer(input logic [7:0] d, input logic ai);
        logic [7:0] r;
        logic a;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], r[i]);
        bit_io(ai, a);
        rd_d = {a, r};
        rd_v = ~rd_v;
    endtask
endmodule

// [verif/adc_i2c_result_port_tb_top.sv]
/* self-checking bench for the result port.
   assumes the bus master model and the bound checker. */
`timescale 1ns/10ps
module adc_i2c_result_port_tb_top;
    import adc_pkg::*;
    // short conversions keep the run brief
    localparam int unsigned TC = 2000;
    logic clk, conv_clk, reset, scl, pull, drive_n, rd_v, conv_run;
    logic signed [19:0] smp;
    logic [8:0] rd_d;
    adc_pins_t pins;
    adc_cfg_t cfg;
    logic [8:0] exp_q[$];
    int num_errors, checked;
    // pins then address
    logic [11:0] tbl[7] = '{12'h214, 12'h115, 12'h617, 12'h524, 12'ha26, 12'h927, 12'h194};
    // open drain wire with pull-up
    wire sda = ~(pull | ~drive_n);
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // filter clock, unrelated phase
    initial
    begin
        conv_clk = 1'b0;
        #3.3;
        forever #7.5 conv_clk = ~conv_clk;
    end
    adc_i2c_result_port #(.T60_CYC(TC), .T50_CYC(TC), .TBOTH_CYC(TC), .T60_2X_CYC(TC),
        .T50_2X_CYC(TC), .TBOTH_2X_CYC(TC)) dut (.clk(clk), .reset(reset), .scl(scl),
        .sda_in(sda), .sda_out(), .sda_drive_n(drive_n), .pins(pins), .conv_clk(conv_clk),
        .conv_sample(smp), .conv_run(conv_run), .conv_cfg(cfg));
    adc_i2c_master m (.clk(clk), .scl(scl), .sda_pull(pull), .sda(sda), .rd_v(rd_v),
        .rd_d(rd_d));
    task automatic check(input logic [8:0] s, input logic [8:0] e);
        checked++;
        if (s !== e)
        begin
            num_errors++;
            $display("wrong value at %0t: got %h want %h", $time, s, e);
        end
    endtask
    task automatic final_report;
        if (num_errors == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // expected word: clamped offset code, then settings readback
    function automatic logic [23:0] word(input logic signed [19:0] s, input logic [6:0] c);
        logic signed [19:0] v;
        v = s > 20'sh10000 ? 20'sh10000 : s < -20'sh10001 ? -20'sh10001 : s;
        return {v[17:0] + 18'h20000, c[5:0]};
    endfunction
    // note the expectation, then move the byte
    task automatic op(input logic [7:0] d, input logic ai, input logic [8:0] e);
        exp_q.push_back(e);
        m.xfer(d, ai);
    endtask
    // bounded wait for the end of a conversion and its capture
    task automatic wait_done;
        int n;
        repeat (20) @(posedge clk);
        for (n = 0; n < 3 * TC && conv_run !== 1'b0; n++)
            @(posedge clk);
        repeat (20) @(posedge clk);
        #1;
    endtask
    task automatic rd_word(input logic [6:0] a, input logic [23:0] w);
        m.start;
        op({a, 1'b1}, 1'b1, {1'b0, a, 1'b1});
        for (int i = 2; i >= 0; i--)
            op(8'hff, 1'b0, {1'b0, w[i*8 +: 8]});
    endtask
    // monitor: oldest note against each byte seen
    always @(rd_v)
        if ($time > 0)
            check(rd_d, exp_q.pop_front());
    initial
    begin
        #(TC * 200);
        num_errors++;
        final_report;
    end
    initial
    begin
        logic [6:0] c;
        logic [23:0] w;
        void'($urandom(32'hcff3));
        reset = 1'b1;
        pins = 5'h04;
        smp = 20'sh00000;
        repeat (2) @(posedge clk);
        #1;
        reset = 1'b0;
        // first conversion still running: refused
        m.start;
        op(8'h29, 1'b1, 9'h129);
        m.stop;
        foreach (tbl[i])
        begin
            pins = tbl[i][11:7];
            smp = $signed(20'($urandom)) >>> ($urandom % 5);
            wait_done;
            rd_word(tbl[i][6:0], word(smp, 7'h00));
            m.start;
            op({tbl[i][6:0], 1'b1}, 1'b1, {1'b1, tbl[i][6:0], 1'b1});
            m.stop;
            check({8'h00, conv_run}, 9'h001);
        end
        // write settings, repeated start, read back
        c = 7'($urandom) & 7'h6f;
        wait_done;
        m.start;
        op(8'h28, 1'b1, 9'h028);
        op({1'b0, c}, 1'b1, {2'h0, c});
        rd_word(7'h14, word(smp, c));
        m.stop;
        check({2'h0, cfg}, {2'h0, c[6] ? {c[6:4], 4'h0} : c});
        // global read refused, global write restarts
        wait_done;
        m.start;
        op(8'hef, 1'b1, 9'h1ef);
        m.start;
        op(8'hee, 1'b1, 9'h0ee);
        op(8'h08, 1'b1, 9'h008);
        m.stop;
        // zero input in double speed: first such reading shows sign high
        smp = 20'sh00000;
        check({8'h00, conv_run}, 9'h001);
        check({2'h0, cfg}, 9'h008);
        // foreign address, then read aborted after one byte
        wait_done;
        m.start;
        op(8'h4d, 1'b1, 9'h14d);
        m.start;
        op(8'h29, 1'b1, 9'h029);
        w = word(smp, 7'h08);
        op(8'hff, 1'b1, {1'b1, w[23:16]});
        m.stop;
        check({8'h00, conv_run}, 9'h001);
        final_report;
    end
endmodule
